/* logic/coef_decode.sv */
// Combinational decode of mantissa and exponent fields into effective gains
`timescale 1ns/1ps
module coef_decode (
  coef_if.decoder cif
);
  import coef_pkg::*;

  // Stored as a magnitude, used as a negative gain
  function automatic logic signed [NEG_MANT_W:0] negate(input logic [NEG_MANT_W-1:0] m);
    return -$signed({1'b0, m});
  endfunction

  // Gain is mantissa * 2^-rshift; rshift goes negative when front-end plus back-end exceed 16 plus shift
  assign cif.alpha_gain = cif.alpha_mant;
  assign cif.alpha_rshift = ALPHA_BASE + RSHIFT_W'(cif.alpha_shift)
    - RSHIFT_W'(cif.alpha_fe) - RSHIFT_W'(cif.alpha_be);

  generate
    for (genvar i = 0; i < 2; i++) begin : g_neg
      assign cif.neg_gain[i] = negate(cif.neg_mant[i]);
      assign cif.neg_rshift[i] = NEG_BASE + SMALL_RSHIFT_W'(cif.neg_exp[i]);
    end
  endgenerate

  assign cif.delta_gain = cif.delta_mant;
  assign cif.delta_rshift = DELTA_BASE + SMALL_RSHIFT_W'(cif.delta_exp);

  // Divider assumes one more than the stored integer value
  assign cif.div_int = {1'b0, cif.fb_int} + (DIV_INT_W + 1)'(1);
endmodule

/* logic/coef_if.sv */
// Raw coefficient fields and their decoded gains, between the register file and the decoder
`timescale 1ns/1ps
interface coef_if;
  import coef_pkg::*;

  logic [ALPHA_MANT_W-1:0] alpha_mant;
  logic [SHIFT_W-1:0] alpha_shift;
  logic [FE_W-1:0] alpha_fe;
  logic [BE_W-1:0] alpha_be;
  logic [NEG_MANT_W-1:0] neg_mant [2];
  logic [EXP_W-1:0] neg_exp [2];
  logic [DELTA_MANT_W-1:0] delta_mant;
  logic [EXP_W-1:0] delta_exp;
  logic [DIV_INT_W-1:0] fb_int;

  logic [ALPHA_MANT_W-1:0] alpha_gain;
  logic signed [RSHIFT_W-1:0] alpha_rshift;
  logic signed [NEG_MANT_W:0] neg_gain [2];
  logic [SMALL_RSHIFT_W-1:0] neg_rshift [2];
  logic [DELTA_MANT_W-1:0] delta_gain;
  logic [SMALL_RSHIFT_W-1:0] delta_rshift;
  logic [DIV_INT_W:0] div_int;

  modport decoder (
    input alpha_mant, alpha_shift, alpha_fe, alpha_be, neg_mant, neg_exp,
    input delta_mant, delta_exp, fb_int,
    output alpha_gain, alpha_rshift, neg_gain, neg_rshift, delta_gain, delta_rshift,
    output div_int
  );
  modport core (
    output alpha_mant, alpha_shift, alpha_fe, alpha_be, neg_mant, neg_exp,
    output delta_mant, delta_exp, fb_int,
    input alpha_gain, alpha_rshift, neg_gain, neg_rshift, delta_gain, delta_rshift,
    input div_int
  );
endinterface

/* logic/coef_pkg.sv */
// Register map, field layout and decode constants of the loop filter coefficient stage
package coef_pkg;

  typedef logic [31:0] word_type;

  // Register indices; byte address is four times the index
  localparam int NUM_RW = 10;
  localparam logic [3:0] IDX_ALPHA_MANT = 4'h0;
  localparam logic [3:0] IDX_ALPHA_EXP = 4'h1;
  localparam logic [3:0] IDX_BETA_MANT = 4'h2;
  localparam logic [3:0] IDX_BETA_EXP = 4'h3;
  localparam logic [3:0] IDX_GAMMA_MANT = 4'h4;
  localparam logic [3:0] IDX_GAMMA_EXP = 4'h5;
  localparam logic [3:0] IDX_DELTA_MANT = 4'h6;
  localparam logic [3:0] IDX_DELTA_EXP = 4'h7;
  localparam logic [3:0] IDX_FB_INT = 4'h8;
  localparam logic [3:0] IDX_FB_FRAC = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;

  typedef word_type cfg_array_type [NUM_RW];

  // Address decode
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_W = 4;
  localparam int ADDR_DECODE_LSB = 6;

  // Field widths
  localparam int ALPHA_MANT_W = 16;
  localparam int SHIFT_W = 6;
  localparam int FE_W = 3;
  localparam int BE_W = 4;
  localparam int NEG_MANT_W = 17;
  localparam int EXP_W = 5;
  localparam int DELTA_MANT_W = 15;
  localparam int DIV_INT_W = 30;
  localparam int FRAC_W = 10;
  localparam int RSHIFT_W = 8;
  localparam int SMALL_RSHIFT_W = 6;

  // Field positions
  localparam int ALPHA_SHIFT_LSB = 0;
  localparam int ALPHA_FE_LSB = 8;
  localparam int ALPHA_BE_LSB = 16;
  localparam int FRAC_NUM_LSB = 0;
  localparam int FRAC_DEN_LSB = 16;
  localparam int STAT_RSHIFT_LSB = 0;
  localparam int STAT_ZERO_LSB = 8;

  // Fixed exponent offsets of each coefficient
  localparam logic [RSHIFT_W-1:0] ALPHA_BASE = 8'h10;
  localparam logic [SMALL_RSHIFT_W-1:0] NEG_BASE = 6'h11;
  localparam logic [SMALL_RSHIFT_W-1:0] DELTA_BASE = 6'h0F;

  // Writable bits and reset values per register
  localparam word_type REG_MASK [NUM_RW] = '{
    32'h0000FFFF, 32'h000F073F, 32'h0001FFFF, 32'h0000001F, 32'h0001FFFF,
    32'h0000001F, 32'h00007FFF, 32'h0000001F, 32'h3FFFFFFF, 32'h03FF03FF};
  localparam word_type REG_RESET [NUM_RW] = '{
    32'h00000001, 32'h00000000, 32'h00000001, 32'h00000000, 32'h00000001,
    32'h00000000, 32'h00000001, 32'h00000000, 32'h00000000, 32'h00010000};

endpackage

/* logic/loop_filter_coef.sv */
// Loop filter coefficient registers on AHB-Lite with decoded gain outputs
//
// How it works
// - Coefficients are stored as mantissa plus exponent fields, not floating point.
// - Second and third coefficients are stored as magnitudes and negated internally.
// - First gain is mantissa times 2^-(16 + shift - frontend - backend).
// - Shift field 0..63 moves the binary point left for small values.
// - Front-end field 0..7 multiplies by a power of two.
// - Back-end field adds up to 15 further doublings at the output side.
// - Second magnitude is 17-bit mantissa times 2^-(17 + exponent 0..31).
// - Third magnitude is 17-bit mantissa times 2^-(17 + exponent 0..31).
// - Fourth gain is positive 15-bit mantissa times 2^-(15 + exponent 0..31).
// - Integer divide ratio is stored value plus one; fraction is num over den.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module loop_filter_coef (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire coef_pkg::word_type haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire coef_pkg::word_type hwdata,
  input wire logic hready,
  output coef_pkg::word_type hrdata,
  output logic hreadyout,
  output logic hresp,
  // Decoded coefficients to the filter core
  output logic [coef_pkg::ALPHA_MANT_W-1:0] alpha_gain,
  output logic signed [coef_pkg::RSHIFT_W-1:0] alpha_rshift,
  output logic signed [coef_pkg::NEG_MANT_W:0] beta_gain,
  output logic [coef_pkg::SMALL_RSHIFT_W-1:0] beta_rshift,
  output logic signed [coef_pkg::NEG_MANT_W:0] gamma_gain,
  output logic [coef_pkg::SMALL_RSHIFT_W-1:0] gamma_rshift,
  output logic [coef_pkg::DELTA_MANT_W-1:0] delta_gain,
  output logic [coef_pkg::SMALL_RSHIFT_W-1:0] delta_rshift,
  // Feedback divide ratio
  output logic [coef_pkg::DIV_INT_W:0] div_int,
  output logic [coef_pkg::FRAC_W-1:0] div_frac_num,
  output logic [coef_pkg::FRAC_W-1:0] div_frac_den
);
  import coef_pkg::*;

  function automatic logic mapped(input word_type a);
    return a[31:ADDR_DECODE_LSB] == '0 && a[ADDR_IDX_LSB +: ADDR_IDX_W] <= IDX_STATUS;
  endfunction

  function automatic logic [ADDR_IDX_W-1:0] reg_index(input word_type a);
    return a[ADDR_IDX_LSB +: ADDR_IDX_W];
  endfunction

  coef_if cif();
  coef_decode u_dec (
    .cif(cif)
  );

  cfg_array_type cfg;
  cfg_array_type next_cfg;
  logic wr_pend;
  logic next_wr_pend;
  logic [ADDR_IDX_W-1:0] wr_idx;
  logic [ADDR_IDX_W-1:0] next_wr_idx;
  word_type next_hrdata;
  word_type status;

  // Raw fields to the decoder
  assign cif.alpha_mant = cfg[IDX_ALPHA_MANT][ALPHA_MANT_W-1:0];
  assign cif.alpha_shift = cfg[IDX_ALPHA_EXP][ALPHA_SHIFT_LSB +: SHIFT_W];
  assign cif.alpha_fe = cfg[IDX_ALPHA_EXP][ALPHA_FE_LSB +: FE_W];
  assign cif.alpha_be = cfg[IDX_ALPHA_EXP][ALPHA_BE_LSB +: BE_W];
  assign cif.neg_mant[0] = cfg[IDX_BETA_MANT][NEG_MANT_W-1:0];
  assign cif.neg_exp[0] = cfg[IDX_BETA_EXP][EXP_W-1:0];
  assign cif.neg_mant[1] = cfg[IDX_GAMMA_MANT][NEG_MANT_W-1:0];
  assign cif.neg_exp[1] = cfg[IDX_GAMMA_EXP][EXP_W-1:0];
  assign cif.delta_mant = cfg[IDX_DELTA_MANT][DELTA_MANT_W-1:0];
  assign cif.delta_exp = cfg[IDX_DELTA_EXP][EXP_W-1:0];
  assign cif.fb_int = cfg[IDX_FB_INT][DIV_INT_W-1:0];

  // Zero mantissas are flagged rather than clamped, so software can see its own slip
  always_comb begin
    status = '0;
    status[STAT_RSHIFT_LSB +: RSHIFT_W] = alpha_rshift;
    status[STAT_ZERO_LSB] = alpha_gain == '0;
    status[STAT_ZERO_LSB + 1] = beta_gain == '0;
    status[STAT_ZERO_LSB + 2] = gamma_gain == '0;
    status[STAT_ZERO_LSB + 3] = delta_gain == '0;
  end

  // Reads of stored registers sample the post-write values so a write followed at once by a read is seen; status reads use the registered outputs
  always_comb begin
    next_cfg = cfg;
    next_wr_pend = 1'b0;
    next_wr_idx = wr_idx;
    next_hrdata = hrdata;
    if (wr_pend) begin
      next_cfg[wr_idx] = hwdata & REG_MASK[wr_idx];
    end
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        next_wr_pend = mapped(haddr) && reg_index(haddr) != IDX_STATUS;
        next_wr_idx = reg_index(haddr);
      end else if (!mapped(haddr)) begin
        next_hrdata = '0;
      end else if (reg_index(haddr) == IDX_STATUS) begin
        next_hrdata = status;
      end else begin
        next_hrdata = next_cfg[reg_index(haddr)];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= REG_RESET;
      wr_pend <= 1'b0;
      wr_idx <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      cfg <= next_cfg;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Outputs registered one cycle behind the configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alpha_gain <= '0;
      alpha_rshift <= '0;
      beta_gain <= '0;
      beta_rshift <= '0;
      gamma_gain <= '0;
      gamma_rshift <= '0;
      delta_gain <= '0;
      delta_rshift <= '0;
      div_int <= '0;
      div_frac_num <= '0;
      div_frac_den <= '0;
    end else begin
      alpha_gain <= cif.alpha_gain;
      alpha_rshift <= cif.alpha_rshift;
      beta_gain <= cif.neg_gain[0];
      beta_rshift <= cif.neg_rshift[0];
      gamma_gain <= cif.neg_gain[1];
      gamma_rshift <= cif.neg_rshift[1];
      delta_gain <= cif.delta_gain;
      delta_rshift <= cif.delta_rshift;
      div_int <= cif.div_int;
      div_frac_num <= cfg[IDX_FB_FRAC][FRAC_NUM_LSB +: FRAC_W];
      div_frac_den <= cfg[IDX_FB_FRAC][FRAC_DEN_LSB +: FRAC_W];
    end
  end

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_alpha_mant;
  logic wr_alpha_exp;
  logic wr_beta_mant;
  logic wr_beta_exp;
  logic wr_gamma_mant;
  logic wr_gamma_exp;
  logic wr_delta;
  logic wr_fb;
  assign wr_alpha_mant = wr_pend && wr_idx == IDX_ALPHA_MANT;
  assign wr_alpha_exp = wr_pend && wr_idx == IDX_ALPHA_EXP;
  assign wr_beta_mant = wr_pend && wr_idx == IDX_BETA_MANT;
  assign wr_beta_exp = wr_pend && wr_idx == IDX_BETA_EXP;
  assign wr_gamma_mant = wr_pend && wr_idx == IDX_GAMMA_MANT;
  assign wr_gamma_exp = wr_pend && wr_idx == IDX_GAMMA_EXP;
  assign wr_delta = wr_pend && (wr_idx == IDX_DELTA_MANT || wr_idx == IDX_DELTA_EXP);
  assign wr_fb = wr_pend && wr_idx == IDX_FB_INT;

  property p_alpha_mant;
    wr_alpha_mant |-> ##2 alpha_gain == $past(hwdata[ALPHA_MANT_W-1:0], 2);
  endproperty
  a_alpha_mant: assert property (p_alpha_mant) else $error("alpha mantissa not taken");

  property p_alpha_rshift;
    wr_alpha_exp |-> ##2 alpha_rshift == RSHIFT_W'(ALPHA_BASE
      + RSHIFT_W'($past(hwdata[ALPHA_SHIFT_LSB +: SHIFT_W], 2))
      - RSHIFT_W'($past(hwdata[ALPHA_FE_LSB +: FE_W], 2))
      - RSHIFT_W'($past(hwdata[ALPHA_BE_LSB +: BE_W], 2)));
  endproperty
  a_alpha_rshift: assert property (p_alpha_rshift) else $error("alpha exponent wrong");

  property p_shift_only;
    wr_alpha_exp && hwdata[ALPHA_FE_LSB +: FE_W] == '0 && hwdata[ALPHA_BE_LSB +: BE_W] == '0
      |-> ##2 alpha_rshift >= $signed(ALPHA_BASE);
  endproperty
  a_shift_only: assert property (p_shift_only) else $error("shift moved point right");

  property p_fe_be;
    wr_alpha_exp && hwdata[ALPHA_SHIFT_LSB +: SHIFT_W] == '0 |-> ##2
      alpha_rshift <= $signed(ALPHA_BASE) && alpha_rshift >= $signed(8'h10 - 8'h07 - 8'h0F);
  endproperty
  a_fe_be: assert property (p_fe_be) else $error("gain fields out of range");

  property p_beta;
    wr_beta_mant |-> ##2 beta_gain == -$signed({1'b0, $past(hwdata[NEG_MANT_W-1:0], 2)});
  endproperty
  a_beta: assert property (p_beta) else $error("beta not negated");

  property p_beta_exp;
    wr_beta_exp |-> ##2 beta_rshift == NEG_BASE + SMALL_RSHIFT_W'($past(hwdata[EXP_W-1:0], 2));
  endproperty
  a_beta_exp: assert property (p_beta_exp) else $error("beta exponent wrong");

  property p_gamma;
    wr_gamma_mant |-> ##2 gamma_gain == -$signed({1'b0, $past(hwdata[NEG_MANT_W-1:0], 2)});
  endproperty
  a_gamma: assert property (p_gamma) else $error("gamma not negated");

  property p_gamma_exp;
    wr_gamma_exp |-> ##2
      gamma_rshift == NEG_BASE + SMALL_RSHIFT_W'($past(hwdata[EXP_W-1:0], 2));
  endproperty
  a_gamma_exp: assert property (p_gamma_exp) else $error("gamma exponent wrong");

  property p_delta;
    wr_delta |-> ##2 delta_rshift == DELTA_BASE + SMALL_RSHIFT_W'($past(cif.delta_exp))
      && delta_gain == $past(cif.delta_mant);
  endproperty
  a_delta: assert property (p_delta) else $error("delta decode wrong");

  property p_div;
    wr_fb |-> ##2 div_int == (DIV_INT_W + 1)'($past(hwdata[DIV_INT_W-1:0], 2)) + 31'h1;
  endproperty
  a_div: assert property (p_div) else $error("divide ratio not plus one");

  c_alpha_write: cover property (wr_alpha_exp ##2 alpha_rshift < 0);
  c_status_read: cover property (hsel && hready && htrans[1] && !hwrite
    && reg_index(haddr) == IDX_STATUS);
  c_beta_write: cover property (wr_beta_mant ##2 wr_beta_exp);
endmodule

/* test/testbench.sv */
// Self-checking bench for the loop filter coefficient register block
`timescale 1ns/1ps
module testbench;
  import coef_pkg::*;
  // Clock and reset
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  // Bus
  logic hsel = 1'b0;
  word_type haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  word_type hwdata = 32'h0;
  logic hready;
  word_type hrdata;
  logic hreadyout;
  logic hresp;
  // Decoded gains
  logic [15:0] alpha_gain;
  logic signed [7:0] alpha_rshift;
  logic signed [17:0] beta_gain;
  logic [5:0] beta_rshift;
  logic signed [17:0] gamma_gain;
  logic [5:0] gamma_rshift;
  logic [14:0] delta_gain;
  logic [5:0] delta_rshift;
  logic [30:0] div_int;
  logic [9:0] div_frac_num;
  logic [9:0] div_frac_den;
  // Reference model state
  word_type regs [10];
  word_type mask [10];
  word_type rst_regs [10];
  int err_count = 0;
  int n_tests = 0;

  loop_filter_coef dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .alpha_gain, .alpha_rshift, .beta_gain,
    .beta_rshift, .gamma_gain, .gamma_rshift, .delta_gain, .delta_rshift,
    .div_int, .div_frac_num, .div_frac_den
  );

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  always #4 hclk = ~hclk;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input word_type got, input word_type exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        $display("CHECK FAILED at %0t: bus timeout", $time);
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input word_type a, input word_type wd,
                     output word_type rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  function automatic int alpha_rs();
    int r;
    r = 16 + regs[1][5:0] - regs[1][10:8] - regs[1][19:16];
    return r;
  endfunction

  task automatic wr(input word_type a, input word_type v);
    word_type d;
    bus(1'b1, a, v, d);
    // Unmapped and read-only places keep their contents
    if (a[31:6] == 0 && a[5:2] < 10) begin
      regs[a[5:2]] = v & mask[a[5:2]];
    end
  endtask

  task automatic rd_chk(input word_type a);
    word_type d;
    word_type e;
    int r;
    r = alpha_rs();
    bus(1'b0, a, 32'h0, d);
    e = 32'h0;
    if (a[31:6] == 0 && a[5:2] < 10) begin
      e = regs[a[5:2]];
    end else if (a[31:6] == 0 && a[5:2] == 10) begin
      e = {20'h0, regs[6] == 0, regs[4] == 0, regs[2] == 0, regs[0] == 0, r[7:0]};
    end
    cmp(d, e, "read data");
    cmp({31'h0, hresp}, 32'h0, "response");
    cmp({31'h0, hreadyout}, 32'h1, "ready");
  endtask

  // Decoded outputs settle one edge after the store edge; checked two edges after it
  task automatic check_out();
    int r;
    repeat (2) @(posedge hclk);
    r = alpha_rs();
    cmp({16'h0, alpha_gain}, regs[0], "alpha gain");
    cmp({24'h0, alpha_rshift}, r & 32'hFF, "alpha shift");
    cmp({14'h0, beta_gain}, (0 - regs[2]) & 32'h3FFFF, "beta gain");
    cmp({26'h0, beta_rshift}, 17 + regs[3], "beta shift");
    cmp({14'h0, gamma_gain}, (0 - regs[4]) & 32'h3FFFF, "gamma gain");
    cmp({26'h0, gamma_rshift}, 17 + regs[5], "gamma shift");
    cmp({17'h0, delta_gain}, regs[6], "delta gain");
    cmp({26'h0, delta_rshift}, 15 + regs[7], "delta shift");
    cmp({1'h0, div_int}, regs[8] + 1, "div int");
    cmp({22'h0, div_frac_num}, regs[9] & 32'h3FF, "frac num");
    cmp({22'h0, div_frac_den}, regs[9] >> 16, "frac den");
  endtask

  task automatic read_all();
    for (int i = 0; i < 12; i++) begin
      rd_chk(i * 4);
    end
    rd_chk(32'h40);
  endtask

  initial begin
    word_type v;
    word_type aexp [4];
    rst_regs = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h10000};
    regs = rst_regs;
    mask = '{32'hFFFF, 32'hF073F, 32'h1FFFF, 32'h1F, 32'h1FFFF, 32'h1F, 32'h7FFF,
             32'h1F, 32'h3FFFFFFF, 32'h3FF03FF};
    aexp = '{32'hF073F, 32'hF0700, 32'h700, 32'h3F};
    void'($urandom(32'h8E86));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    check_out();
    read_all();
    // Worked quantised example of all four gains
    wr(32'h00, 32'd53416);
    wr(32'h04, 32'd6);
    wr(32'h08, 32'd75019);
    wr(32'h0C, 32'd13);
    wr(32'h10, 32'd80571);
    wr(32'h14, 32'd13);
    wr(32'h18, 32'd16906);
    wr(32'h1C, 32'd8);
    check_out();
    // Extremes of shift, front-end and back-end fields
    for (int k = 0; k < 4; k++) begin
      wr(32'h04, aexp[k]);
      check_out();
    end
    // Random whole words, unwritable bits included
    for (int n = 0; n < 20; n++) begin
      for (int i = 0; i < 10; i++) begin
        v = $urandom();
        if (i < 8 && i % 2 == 0 && (v & mask[i]) == 0) begin
          v = 32'h1;
        end
        // Software only uses back-end gain once the front-end field is full
        if (i == 1 && v[10:8] != 3'h7) begin
          v[19:16] = 4'h0;
        end
        wr(i * 4, v);
      end
      check_out();
      read_all();
    end
    // Read-only and unmapped writes are dropped
    wr(32'h28, 32'hFFFFFFFF);
    wr(32'h2C, 32'hFFFFFFFF);
    wr(32'h40, 32'hFFFFFFFF);
    read_all();
    check_out();
    // Reset in mid-run brings every register back to its reset value
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    regs = rst_regs;
    check_out();
    read_all();
    end_of_test();
  end
endmodule
